// [verilog/ldoi2c_slave.v]
// Purpose : Serial-bus target port giving a bus master access to eight
//           byte registers of the regulator chip.
// Assumes : scl and sda are already synchronous to clk_sys, which runs far
//           faster than the bus, so every bus edge spans many clocks.
// Notes   : sda is open drain; the port only ever pulls it low.
`timescale 1ns/1ps
`default_nettype none
`include "ldoi2c_defs.vh"

module ldoi2c_slave #(
  parameter [6:0] TARGET_ADDR = `LDOI2C_TARGET_ADDR,
  parameter [2:0] ANA_IDX     = `LDOI2C_ANA_REG_IDX,
  parameter       ANA_LSB     = `LDOI2C_ANA_CODE_LSB
) (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // Serial bus, clock from the master
  input  wire        scl,
  // Serial bus data, open drain
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  // Register contents for the regulators
  output wire [63:0] regs_flat,
  // Analog rail setting decoded from its code
  output reg  [11:0] analog_rail_mv,
  // Port status
  output wire        busy
);

  // ----------------------------------------------------------------------------
  // States, one-hot
  // ----------------------------------------------------------------------------
  localparam [9:0] ST_IDLE   = 10'h001;
  localparam [9:0] ST_ADDR   = 10'h002;
  localparam [9:0] ST_AACK   = 10'h004;
  localparam [9:0] ST_REG    = 10'h008;
  localparam [9:0] ST_RACK   = 10'h010;
  localparam [9:0] ST_WDATA  = 10'h020;
  localparam [9:0] ST_WACK   = 10'h040;
  localparam [9:0] ST_RDATA  = 10'h080;
  localparam [9:0] ST_MACK   = 10'h100;
  localparam [9:0] ST_IGNORE = 10'h200;

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  // True when a received address header selects this port.
  function addr_match;
    input [6:0] hdr;
    begin
      addr_match = (hdr == TARGET_ADDR) &&
                   (hdr != `LDOI2C_GCALL_ADDR) &&
                   (hdr[6:2] != `LDOI2C_TENBIT_PREFIX);
    end
  endfunction

  // True when a register address names an implemented register.
  function in_range;
    input [7:0] ra;
    begin
      in_range = (ra[7:3] == 5'h00);
    end
  endfunction

  // Millivolts selected by a three-bit rail code.
  function [11:0] volt_mv;
    input [2:0] code;
    reg [11:0] steps;
    begin
      steps   = 12'h000;
      steps   = {9'h000, code} * `LDOI2C_VOLT_STEP_MV;
      volt_mv = `LDOI2C_VOLT_BASE_MV + steps;
    end
  endfunction

  // ----------------------------------------------------------------------------
  // Bus sampling and condition detection
  // ----------------------------------------------------------------------------
  reg        scl_q;
  reg        sda_q;
  reg  [9:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift;
  reg  [7:0] reg_ptr;
  reg        rw_bit;
  reg        wr_en;
  reg  [7:0] wr_data;
  wire [7:0] rf_data;
  wire [7:0] rd_byte;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;
  wire       byte_done;

  // Previous bus levels for edge and condition detection.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // Data changing while the clock is high marks start or stop.
  assign scl_rise   = scl & ~scl_q;
  assign scl_fall   = ~scl & scl_q;
  assign start_cond = scl & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl & scl_q & ~sda_q & sda_in;
  assign byte_done  = (bit_cnt == `LDOI2C_BITS_PER_BYTE);
  assign sda_out    = 1'b0;
  assign busy       = (state != ST_IDLE);

  // Out-of-range pointers read back as zero.
  assign rd_byte = in_range(reg_ptr) ? rf_data : 8'h00;

  // ----------------------------------------------------------------------------
  // Transfer state machine
  // ----------------------------------------------------------------------------
  // Bits are taken on the rising clock; the line is changed on the falling
  // clock so the master never sees data move while the clock is high.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      reg_ptr <= 8'h00;
      rw_bit  <= 1'b0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (start_cond) begin
        // Start or repeated start; the pointer is deliberately kept.
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_cond) begin
        // Stop frees the bus but keeps the pointer for a later read.
        state   <= ST_IDLE;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_done) begin
              bit_cnt <= 4'h0;
              rw_bit  <= shift[0];
              if (addr_match(shift[7:1])) begin
                state  <= ST_AACK;
                sda_oe <= 1'b1;
              end else begin
                state <= ST_IGNORE;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw_bit == `LDOI2C_RW_READ) begin
                // Read header: drive the first data bit at once.
                state  <= ST_RDATA;
                sda_oe <= ~rd_byte[7];
                shift  <= {rd_byte[6:0], 1'b1};
              end else begin
                state  <= ST_REG;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_REG: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_done) begin
              bit_cnt <= 4'h0;
              reg_ptr <= shift;
              state   <= ST_RACK;
              sda_oe  <= 1'b1;
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              state  <= ST_WDATA;
              sda_oe <= 1'b0;
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_in};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && byte_done) begin
              bit_cnt <= 4'h0;
              wr_data <= shift;
              wr_en   <= in_range(reg_ptr);
              state   <= ST_WACK;
              sda_oe  <= 1'b1;
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              // Only one data byte per write; extra bytes are not taken.
              state  <= ST_IGNORE;
              sda_oe <= 1'b0;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (byte_done) begin
                bit_cnt <= 4'h0;
                state   <= ST_MACK;
                sda_oe  <= 1'b0;
              end else begin
                sda_oe <= ~shift[7];
                shift  <= {shift[6:0], 1'b1};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise && sda_in) begin
              // Master declined further data; leave the line alone.
              state  <= ST_IGNORE;
              sda_oe <= 1'b0;
            end else if (scl_fall) begin
              // Master asked for more: resend the same register.
              state  <= ST_RDATA;
              sda_oe <= ~rd_byte[7];
              shift  <= {rd_byte[6:0], 1'b1};
            end
          end
          ST_IGNORE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------------
  // The read index follows the pointer so the byte is ready long before the
  // falling clock that drives its first bit.
  ldoi2c_regfile #(
    .DEPTH  (`LDOI2C_NUM_REGS),
    .DATA_W (`LDOI2C_DATA_W),
    .IDX_W  (`LDOI2C_IDX_W)
  ) u_regfile (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .wr_en     (wr_en),
    .wr_idx    (reg_ptr[2:0]),
    .wr_data   (wr_data),
    .rd_idx    (reg_ptr[2:0]),
    .rd_data   (rf_data),
    .regs_flat (regs_flat)
  );

  // ----------------------------------------------------------------------------
  // Analog rail voltage decode
  // ----------------------------------------------------------------------------
  // The rail code sits in a field of one register; decode it to millivolts.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      analog_rail_mv <= `LDOI2C_VOLT_BASE_MV;
    end else begin
      analog_rail_mv <= volt_mv(regs_flat[ANA_IDX*8 + ANA_LSB +: 3]);
    end
  end

endmodule
`default_nettype wire

// [verilog/ldoi2c_defs.vh]
// Purpose : Shared constants of the regulator serial-bus target port.
// Assumes : Included by its bare name from every design file that needs it.
// Notes   : Definitions only; no logic lives here.
`ifndef LDOI2C_DEFS_VH
`define LDOI2C_DEFS_VH

// ----------------------------------------------------------------------------
// Register file geometry
// ----------------------------------------------------------------------------
`define LDOI2C_NUM_REGS       8
`define LDOI2C_DATA_W         8
`define LDOI2C_IDX_W          3
`define LDOI2C_REG_RESET      8'h00

// ----------------------------------------------------------------------------
// Bus addressing
// ----------------------------------------------------------------------------
`define LDOI2C_TARGET_ADDR    7'h08
`define LDOI2C_GCALL_ADDR     7'h00
`define LDOI2C_TENBIT_PREFIX  5'h1E
`define LDOI2C_RW_READ        1'b1
`define LDOI2C_BITS_PER_BYTE  4'h8

// ----------------------------------------------------------------------------
// Analog rail voltage code, in millivolts
// ----------------------------------------------------------------------------
`define LDOI2C_VOLT_BASE_MV   12'h9F6
`define LDOI2C_VOLT_STEP_MV   12'h032
`define LDOI2C_ANA_REG_IDX    3'h2
`define LDOI2C_ANA_CODE_LSB   5

`endif

// [verilog/ldoi2c_regfile.v]
// Purpose : Eight byte-wide control registers with a registered read port.
// Assumes : Single clock, one write per cycle, writes already range-checked.
// Notes   : All contents are also exported flat for the regulator logic.
`timescale 1ns/1ps
`default_nettype none
`include "ldoi2c_defs.vh"

module ldoi2c_regfile #(
  parameter DEPTH  = `LDOI2C_NUM_REGS,
  parameter DATA_W = `LDOI2C_DATA_W,
  parameter IDX_W  = `LDOI2C_IDX_W
) (
  // Clock and reset
  input  wire                    clk_sys,
  input  wire                    nrst,
  // Write port
  input  wire                    wr_en,
  input  wire [IDX_W-1:0]        wr_idx,
  input  wire [DATA_W-1:0]       wr_data,
  // Read port
  input  wire [IDX_W-1:0]        rd_idx,
  output reg  [DATA_W-1:0]       rd_data,
  // Flat view of all registers
  output wire [DEPTH*DATA_W-1:0] regs_flat
);

  reg [DATA_W-1:0] mem [0:DEPTH-1];
  integer i;

  // ----------------------------------------------------------------------------
  // Storage and registered read
  // ----------------------------------------------------------------------------
  // Each register holds its byte until the port writes it again.
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem[i] <= `LDOI2C_REG_RESET;
      end
      rd_data <= `LDOI2C_REG_RESET;
    end else begin
      if (wr_en) begin
        mem[wr_idx] <= wr_data;
      end
      rd_data <= mem[rd_idx];
    end
  end

  // Flatten the array so the regulator logic sees every setting.
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_flat
      assign regs_flat[g*DATA_W +: DATA_W] = mem[g];
    end
  endgenerate

endmodule
`default_nettype wire

// [dv/ldoi2c_sva.sv]
// Purpose: Bus timing and register checks for the regulator target port.
// Assumes: Bound to ldoi2c_slave; one clock domain.
// Notes: Watches what the port drives and the bus inputs scl and sda_in.
`timescale 1ns/1ps
`default_nettype none
module ldoi2c_sva (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        nrst,
  // Bus and outputs
  input wire logic        scl,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic [63:0] regs_flat,
  input wire logic [11:0] analog_rail_mv,
  input wire logic        busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // Start and stop need the bus clock high on two samples.
  sequence s_start;
    scl && $past(scl) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda_in);
  endsequence
  chk_start_busy: assert property (s_start |-> ##[1:3] busy)
    else $error("busy not raised after start");
  chk_stop_idle: assert property (s_stop |-> ##[1:3] !busy)
    else $error("busy not cleared after stop");
  chk_drive_low: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  chk_idle_quiet: assert property (!busy |-> !sda_oe)
    else $error("data line pulled while idle");
  chk_oe_on_low: assert property ($changed(sda_oe) |-> !scl && !$past(scl))
    else $error("data line moved near a clock edge");
  chk_oe_holds: assert property (scl |-> $stable(sda_oe))
    else $error("data line moved while clock high");
  chk_store_in_ack: assert property ($changed(regs_flat) |-> !scl && sda_oe)
    else $error("register changed outside an acknowledge");
  chk_ack_lasts: assert property ($rose(sda_oe) |-> sda_oe [*4])
    else $error("acknowledge too short");
  chk_rail_code: assert property ($stable(regs_flat[23:21]) [*3] |->
    analog_rail_mv == 12'h9F6 + 12'h032 * regs_flat[23:21])
    else $error("rail voltage does not match its code");
endmodule
bind ldoi2c_slave ldoi2c_sva i_sva (.clk_sys(clk_sys), .nrst(nrst), .scl(scl),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .regs_flat(regs_flat),
  .analog_rail_mv(analog_rail_mv), .busy(busy));
`default_nettype wire

// [dv/ldoi2c_master.sv]
// Purpose: Bus master model that drives the bus clock and pulls data low.
// Assumes: Bus time is compressed; qtr sets a quarter bit period in clocks.
// Notes: The line is released, never driven high.
`timescale 1ns/1ps
`default_nettype none
module ldoi2c_master (
  // Clock
  input  wire logic clk_sys,
  // Bus
  input  wire logic sda_in,
  output var  logic scl,
  output var  logic sda_pull
);
  int qtr = 4;
  // Bus idles high.
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One bit; b high releases the line, s is the level seen mid-high.
  task m_bit(input logic b, output logic s);
    sda_pull <= ~b;
    hold(qtr);
    scl <= 1'b1;
    hold(qtr);
    s = sda_in;
    hold(qtr);
    scl <= 1'b0;
    hold(qtr);
  endtask
  // Start or repeated start.
  task m_start;
    sda_pull <= 1'b0;
    hold(qtr);
    scl <= 1'b1;
    hold(qtr);
    sda_pull <= 1'b1;
    hold(qtr);
    scl <= 1'b0;
    hold(qtr);
  endtask
  // Stop ends every transfer.
  task m_stop;
    sda_pull <= 1'b1;
    hold(qtr);
    scl <= 1'b1;
    hold(qtr);
    sda_pull <= 1'b0;
    hold(qtr);
  endtask
  // Byte MSB first, then the ninth bit sent as ak.
  task m_byte(input logic [7:0] tx, input logic ak, output logic [7:0] rx,
              output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) m_bit(tx[i], rx[i]);
    m_bit(ak, s);
    acked = ~s;
  endtask
endmodule
`default_nettype wire

// [dv/ldo_i2c_register_slave_test.sv]
// Purpose: Self-checking bench for the regulator target port.
// Assumes: Master model drives the bus; the wire is resolved here.
// Notes: img mirrors the expected register contents.
`timescale 1ns/1ps
`default_nettype none
module ldo_i2c_register_slave_test;
  logic        clk_sys, nrst, scl, sda_pull, sda_oe, sda_out, busy, ak;
  wire         sda_in;
  logic [63:0] regs_flat, img;
  logic [11:0] analog_rail_mv;
  logic [7:0]  rx;
  int          mismatches = 0;
  int          check_count = 0;
  assign sda_in = ~(sda_oe | sda_pull);
  ldoi2c_slave i_dut (.clk_sys(clk_sys), .nrst(nrst), .scl(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .regs_flat(regs_flat),
    .analog_rail_mv(analog_rail_mv), .busy(busy));
  ldoi2c_master i_master (.clk_sys(clk_sys), .sda_in(sda_in), .scl(scl),
    .sda_pull(sda_pull));
  task check(input string what, input logic [63:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (mismatches == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Send a byte and judge the device's answer.
  task put(input logic [7:0] b, input logic exp_ack);
    i_master.m_byte(b, 1'b1, rx, ak);
    check("ack", ak, exp_ack);
  endtask
  task wr(input logic [7:0] ra, d);
    i_master.m_start;
    put(8'h10, 1'b1);
    put(ra, 1'b1);
    put(d, 1'b1);
    i_master.m_stop;
    if (ra < 8'h08) img[ra[2:0]*8 +: 8] = d;
    check("regs", regs_flat, img);
  endtask
  // Combined read; the byte is left in rx.
  task rd(input logic [7:0] ra);
    i_master.m_start;
    put(8'h10, 1'b1);
    put(ra, 1'b1);
    i_master.m_start;
    put(8'h11, 1'b1);
    i_master.m_byte(8'hFF, 1'b1, rx, ak);
    check("release", sda_oe, 1'b0);
    i_master.m_stop;
  endtask
  task t_reset;
    check("regs", regs_flat, 64'h0);
    check("rail", analog_rail_mv, 12'h9F6);
    check("busy", busy, 1'b0);
  endtask
  // Write every register, read back in reverse order.
  task t_all_regs;
    for (int i = 0; i < 8; i++) wr(8'(i), 8'h3C ^ 8'(i * 17));
    for (int i = 7; i >= 0; i--) begin
      rd(8'(i));
      check("read", rx, img[i*8 +: 8]);
    end
  endtask
  task t_rail;
    for (int c = 0; c < 8; c++) begin
      wr(8'h02, {3'(c), 5'h0A});
      check("rail", analog_rail_mv, 12'h9F6 + 12'h032 * 12'(c));
    end
  endtask
  // General call, ten-bit header and a foreign address.
  task t_refuse;
    logic [7:0] hdr [3];
    hdr = '{8'h00, 8'hF0, 8'h12};
    for (int i = 0; i < 3; i++) begin
      i_master.m_start;
      put(hdr[i], 1'b0);
      put(8'h01, 1'b0);
      put(8'hFF, 1'b0);
      i_master.m_stop;
      check("regs", regs_flat, img);
    end
  endtask
  // Pointer set at the standard rate, then a foreign transfer with its own
  // register byte and the read at the fast-mode rate.
  task t_stopsep;
    i_master.qtr = 250;
    i_master.m_start;
    put(8'h10, 1'b1);
    put(8'h05, 1'b1);
    i_master.m_stop;
    i_master.qtr = 63;
    i_master.m_start;
    put(8'h12, 1'b0);
    put(8'h03, 1'b0);
    i_master.m_stop;
    i_master.m_start;
    put(8'h11, 1'b1);
    i_master.m_byte(8'hFF, 1'b0, rx, ak);
    check("ptr", rx, img[47:40]);
    i_master.m_byte(8'hFF, 1'b1, rx, ak);
    check("again", rx, img[47:40]);
    i_master.m_stop;
    i_master.qtr = 4;
  endtask
  task t_oob;
    wr(8'h09, 8'hFF);
    rd(8'h09);
    check("oob", rx, 8'h00);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #800000;
    mismatches++;
    tally_and_finish;
  end
  initial begin
    nrst <= 1'b0;
    img = 64'h0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset;
    t_all_regs;
    t_rail;
    t_refuse;
    t_stopsep;
    t_oob;
    tally_and_finish;
  end
endmodule
`default_nettype wire
